// ===== verilog/odm_diag_map.sv
// Added by the designer: register access over AXI4-Lite.
`timescale 1ns/1ps
// Overview of operation
// - temperature: signed 16-bit, 1/256 C steps
// - supply: unsigned 16-bit, 100 uV steps
// - bias: unsigned 16-bit, 2 uA steps
// - transmit power: unsigned, 0.1 uW steps
// - receive power: unsigned, 0.1 uW steps
// - live transmit power at bytes 102/103
// - threshold bytes 23, 24, 25 held
// - calibration bytes 56..94 fixed defaults
// - fixed CHECKSUM_DEFAULT at 95, not a sum of bytes 0..94
// - bit 7 shows hardware transmit-off input
// - bit 6 is writable software transmit-off
// - transmitter off when either is set
// - bit 2 shows transmitter fault
// - bit 1 shows receive signal loss
// - bit 0 low once data ready
// - soft commands act within 100 ms
// - byte 112 holds eight alarm flags
// - byte 113 holds receive power alarms
// - byte 116 warnings in alarm order
// - byte 117 holds receive power warnings
// - flags set beyond low/high threshold
// - space answers at diagnostic address
// - live values high byte first, 96..105
module odm_diag_map import odm_pkg::*; #(
  parameter int SOFT_RESP_CYCLES = SOFT_RESP_CYC
) (
  // clock and reset
  input wire logic clk,
  input wire logic reset,
  // axi4-lite slave
  input wire logic [31:0] s_awaddr,
  input wire logic s_awvalid,
  output logic s_awready,
  input wire logic [31:0] s_wdata,
  input wire logic [3:0] s_wstrb,
  input wire logic s_wvalid,
  output logic s_wready,
  output logic [1:0] s_bresp,
  output logic s_bvalid,
  input wire logic s_bready,
  input wire logic [31:0] s_araddr,
  input wire logic s_arvalid,
  output logic s_arready,
  output logic [31:0] s_rdata,
  output logic [1:0] s_rresp,
  output logic s_rvalid,
  input wire logic s_rready,
  // measurement source, same clock
  input wire odm_meas_s meas_in,
  input wire logic meas_strobe,
  // module pins, asynchronous
  input wire logic tx_off_pin,
  input wire logic tx_fault_pin,
  input wire logic receive_signal_loss_output_pin,
  // transmitter control
  output logic tx_disable
);
  typedef struct packed {
    logic [2:0] hw_sync;
    logic [2:0] flt_sync;
    logic [2:0] los_sync;
    logic hw_off;
    logic fault;
    logic loss;
    logic sw_off;
    logic tx_dis;
    logic ready;
    odm_meas_s meas;
    logic [THR_BYTES*8-1:0] thr;
    logic [7:0] alarm_a;
    logic [1:0] alarm_b;
    logic [7:0] warn_a;
    logic [1:0] warn_b;
    logic aw_got;
    logic [7:0] aw_addr;
    logic w_got;
    logic [7:0] w_data;
    logic w_strb0;
    odm_axi_out_s axi;
  } odm_state_s;

  odm_state_s state_reg;
  odm_state_s state_next;

  // threshold pair fetch, big endian at byte i
  function automatic logic [15:0] thr16(input logic [THR_BYTES*8-1:0] t, input int i);
    thr16 = {t[(THR_BYTES-1-i)*8 +: 8], t[(THR_BYTES-2-i)*8 +: 8]};
  endfunction

  // read decode of one byte of the space
  function automatic logic [7:0] rd_byte(input odm_state_s s, input logic [7:0] a);
    logic [79:0] live;
    live = {s.meas.temp, s.meas.vcc, s.meas.bias, s.meas.txp, s.meas.rxp};
    rd_byte = 8'h00;
    if (a < THR_BYTES[7:0])
      rd_byte = s.thr[(THR_BYTES-1-int'(a))*8 +: 8];
    else if (a >= OFF_CAL_FIRST && a <= OFF_CAL_LAST)
      rd_byte = CAL_DEFAULT;
    else if (a == OFF_CHECKSUM)
      rd_byte = CHECKSUM_DEFAULT;
    else if (a >= OFF_LIVE_BASE && a < OFF_LIVE_BASE + 8'h0a)
      rd_byte = live[(9-int'(a-OFF_LIVE_BASE))*8 +: 8];
    else if (a == OFF_CTRL_STATE)
      rd_byte = {s.hw_off, s.sw_off, 3'b000, s.fault, s.loss, ~s.ready};
    else if (a == OFF_ALARM_A)
      rd_byte = s.alarm_a;
    else if (a == OFF_ALARM_B)
      rd_byte = {s.alarm_b, 6'h00};
    else if (a == OFF_WARN_A)
      rd_byte = s.warn_a;
    else if (a == OFF_WARN_B)
      rd_byte = {s.warn_b, 6'h00};
  endfunction

  // high/low compare pair; temperature compares signed
  function automatic logic [1:0] cmp(input logic [15:0] v, input logic [15:0] hi,
                                     input logic [15:0] lo, input logic sgn);
    if (sgn)
      cmp = {$signed(v) > $signed(hi), $signed(v) < $signed(lo)};
    else
      cmp = {v > hi, v < lo};
  endfunction

  // next-state logic
  always_comb begin
    logic [15:0] q [5];
    logic [7:0] a;
    q = '{default: 16'h0000};
    a = 8'h00;
    state_next = state_reg;
    // pin synchronisers, change accepted when stages 2 and 3 agree
    state_next.hw_sync = {state_reg.hw_sync[1:0], tx_off_pin};
    state_next.flt_sync = {state_reg.flt_sync[1:0], tx_fault_pin};
    state_next.los_sync = {state_reg.los_sync[1:0], receive_signal_loss_output_pin};
    if (state_reg.hw_sync[1] == state_reg.hw_sync[2])
      state_next.hw_off = state_reg.hw_sync[2];
    if (state_reg.flt_sync[1] == state_reg.flt_sync[2])
      state_next.fault = state_reg.flt_sync[2];
    if (state_reg.los_sync[1] == state_reg.los_sync[2])
      state_next.loss = state_reg.los_sync[2];
    // disable follows in one cycle, far inside the response time
    state_next.tx_dis = state_reg.sw_off | state_reg.hw_off;
    // new measurement: store and recompute all flags
    if (meas_strobe) begin
      state_next.meas = meas_in;
      state_next.ready = 1'b1;
      q[0] = meas_in.temp;
      q[1] = meas_in.vcc;
      q[2] = meas_in.bias;
      q[3] = meas_in.txp;
      q[4] = meas_in.rxp;
      for (int i = 0; i < 4; i++) begin
        state_next.alarm_a[7-2*i -: 2] = cmp(q[i], thr16(state_reg.thr, 8*i),
                                             thr16(state_reg.thr, 8*i+2), i == 0);
        state_next.warn_a[7-2*i -: 2] = cmp(q[i], thr16(state_reg.thr, 8*i+4),
                                            thr16(state_reg.thr, 8*i+6), i == 0);
      end
      state_next.alarm_b = cmp(q[4], thr16(state_reg.thr, 32), thr16(state_reg.thr, 34),
                               1'b0);
      state_next.warn_b = cmp(q[4], thr16(state_reg.thr, 36), thr16(state_reg.thr, 38),
                              1'b0);
    end
    // write address and data, either order
    if (s_awvalid && state_reg.axi.awready) begin
      state_next.aw_got = 1'b1;
      state_next.aw_addr = s_awaddr[9:2];
      state_next.axi.awready = 1'b0;
    end
    if (s_wvalid && state_reg.axi.wready) begin
      state_next.w_got = 1'b1;
      state_next.w_data = s_wdata[7:0];
      state_next.w_strb0 = s_wstrb[0];
      state_next.axi.wready = 1'b0;
    end
    // write commit; threshold and control bytes are host writable
    if (state_reg.aw_got && state_reg.w_got && !state_reg.axi.bvalid) begin
      a = state_reg.aw_addr;
      state_next.axi.bvalid = 1'b1;
      state_next.axi.bresp = 2'b00;
      state_next.aw_got = 1'b0;
      state_next.w_got = 1'b0;
      if (a < THR_BYTES[7:0]) begin
        if (state_reg.w_strb0)
          state_next.thr[(THR_BYTES-1-int'(a))*8 +: 8] = state_reg.w_data;
      end else if (a == OFF_CTRL_STATE) begin
        if (state_reg.w_strb0)
          state_next.sw_off = state_reg.w_data[CS_SW_OFF_BIT];
      end else if (a > OFF_WARN_B) begin
        state_next.axi.bresp = 2'b10;
      end
    end
    if (state_reg.axi.bvalid && s_bready) begin
      state_next.axi.bvalid = 1'b0;
      state_next.axi.awready = 1'b1;
      state_next.axi.wready = 1'b1;
    end
    // read channel, one cycle answer
    if (s_arvalid && state_reg.axi.arready) begin
      state_next.axi.arready = 1'b0;
      state_next.axi.rvalid = 1'b1;
      state_next.axi.rdata = {24'h000000, rd_byte(state_reg, s_araddr[9:2])};
      state_next.axi.rresp = (s_araddr[9:2] > OFF_WARN_B) ? 2'b10 : 2'b00;
    end
    if (state_reg.axi.rvalid && s_rready) begin
      state_next.axi.rvalid = 1'b0;
      state_next.axi.arready = 1'b1;
    end
  end

  // state register
  always_ff @(posedge clk or posedge reset) begin
    if (reset) begin
      state_reg <= '0;
      state_reg.axi.awready <= 1'b1;
      state_reg.axi.wready <= 1'b1;
      state_reg.axi.arready <= 1'b1;
    end else begin
      state_reg <= state_next;
    end
  end

  // outputs straight from state flops
  assign s_awready = state_reg.axi.awready;
  assign s_wready = state_reg.axi.wready;
  assign s_bvalid = state_reg.axi.bvalid;
  assign s_bresp = state_reg.axi.bresp;
  assign s_arready = state_reg.axi.arready;
  assign s_rvalid = state_reg.axi.rvalid;
  assign s_rdata = state_reg.axi.rdata;
  assign s_rresp = state_reg.axi.rresp;
  assign tx_disable = state_reg.tx_dis;

  // assertions
  AST_TXDIS_OR: assert property (@(posedge clk) disable iff (reset)
    tx_disable == $past(state_reg.sw_off | state_reg.hw_off))
    else $error("tx_disable not OR of controls");
  AST_SW_OFF_WRITE: assert property (@(posedge clk) disable iff (reset)
    (state_reg.aw_got && state_reg.w_got && !s_bvalid && state_reg.aw_addr == OFF_CTRL_STATE
     && state_reg.w_strb0) |=> state_reg.sw_off == $past(state_reg.w_data[CS_SW_OFF_BIT]))
    else $error("soft off not written");
  AST_SOFT_RESP: assert property (@(posedge clk) disable iff (reset)
    $rose(state_reg.sw_off) |-> ##[1:2] tx_disable)
    else $error("soft off too slow");
  AST_READY: assert property (@(posedge clk) disable iff (reset)
    meas_strobe |=> state_reg.ready)
    else $error("ready not set after measurement");
  AST_NOT_READY: assert property (@(posedge clk) disable iff (reset)
    $rose(state_reg.ready) |-> $past(meas_strobe))
    else $error("ready without measurement");
  AST_RD_ANSWER: assert property (@(posedge clk) disable iff (reset)
    (s_arvalid && s_arready) |=> s_rvalid && s_rdata[31:8] == 24'h000000)
    else $error("read answer malformed");
  AST_RES_B: assert property (@(posedge clk) disable iff (reset)
    s_rvalid |-> !(state_reg.axi.rdata[5:0] != 6'h00 && $past(s_araddr[9:2]) == OFF_ALARM_B
                    && $past(s_arvalid && s_arready)))
    else $error("reserved alarm bits set");
  AST_TXP_HI: assert property (@(posedge clk) disable iff (reset)
    meas_strobe |=> state_reg.alarm_a[1] == (state_reg.meas.txp > $past(thr16(state_reg.thr, 24))))
    else $error("tx power high alarm wrong");
  AST_TEMP_LO: assert property (@(posedge clk) disable iff (reset)
    meas_strobe |=> state_reg.alarm_a[6] ==
      ($signed(state_reg.meas.temp) < $signed($past(thr16(state_reg.thr, 2)))))
    else $error("temp low alarm wrong");

  // read request taken at one byte index
  sequence seq_rd_at(logic [7:0] idx);
    s_arvalid && s_arready && s_araddr[9:2] == idx;
  endsequence
  // both write halves held, answer not yet out
  sequence seq_wr_commit;
    state_reg.aw_got && state_reg.w_got && !s_bvalid;
  endsequence
  // answer raised, both write readys parked low
  sequence seq_wr_answer;
    s_bvalid && !s_awready && !s_wready;
  endsequence
  // second and third stages agree, level may pass
  sequence seq_sync_agree(logic [2:0] sync);
    sync[1] == sync[2];
  endsequence

  // write path answers
  AST_WR_ANSWER: assert property (@(posedge clk) disable iff (reset)
    seq_wr_commit |=> seq_wr_answer)
    else $error("write answer missing");
  AST_WR_SLVERR: assert property (@(posedge clk) disable iff (reset)
    seq_wr_commit ##0 (state_reg.aw_addr > OFF_WARN_B) |=> s_bresp == 2'b10)
    else $error("write outside space not refused");
  AST_WR_OKAY: assert property (@(posedge clk) disable iff (reset)
    seq_wr_commit ##0 (state_reg.aw_addr <= OFF_WARN_B) |=> s_bresp == 2'b00)
    else $error("write inside space refused");
  AST_B_STANDS: assert property (@(posedge clk) disable iff (reset)
    s_bvalid && !s_bready |=> s_bvalid && $stable(s_bresp))
    else $error("write answer dropped early");
  // read path answers
  AST_R_STANDS: assert property (@(posedge clk) disable iff (reset)
    s_rvalid && !s_rready |=> s_rvalid && $stable(s_rdata))
    else $error("read answer dropped early");
  AST_AR_PARKED: assert property (@(posedge clk) disable iff (reset)
    s_rvalid |-> !s_arready)
    else $error("read address taken while answer pending");
  AST_RD_SLVERR: assert property (@(posedge clk) disable iff (reset)
    s_arvalid && s_arready && s_araddr[9:2] > OFF_WARN_B |=> s_rresp == 2'b10)
    else $error("read outside space not refused");
  AST_RD_OKAY: assert property (@(posedge clk) disable iff (reset)
    s_arvalid && s_arready && s_araddr[9:2] <= OFF_WARN_B |=> s_rresp == 2'b00)
    else $error("read inside space refused");
  // pin synchronisers
  AST_HW_SYNC: assert property (@(posedge clk) disable iff (reset)
    seq_sync_agree(state_reg.hw_sync) |=> state_reg.hw_off == $past(state_reg.hw_sync[2]))
    else $error("transmit-off pin level not taken");
  AST_FLT_SYNC: assert property (@(posedge clk) disable iff (reset)
    seq_sync_agree(state_reg.flt_sync) |=> state_reg.fault == $past(state_reg.flt_sync[2]))
    else $error("fault pin level not taken");
  AST_LOS_SYNC: assert property (@(posedge clk) disable iff (reset)
    seq_sync_agree(state_reg.los_sync) |=> state_reg.loss == $past(state_reg.los_sync[2]))
    else $error("signal loss pin level not taken");
  // transmitter follows the hardware input too
  AST_TXDIS_HW: assert property (@(posedge clk) disable iff (reset)
    state_reg.hw_off |=> tx_disable)
    else $error("hardware off ignored");
  // writable state moves only on a commit
  AST_THR_HOLD: assert property (@(posedge clk) disable iff (reset)
    !(state_reg.aw_got && state_reg.w_got && !s_bvalid)
    |=> $stable(state_reg.thr))
    else $error("threshold changed without write");
  AST_SW_HOLD: assert property (@(posedge clk) disable iff (reset)
    !(state_reg.aw_got && state_reg.w_got && !s_bvalid)
    |=> $stable(state_reg.sw_off))
    else $error("soft off changed without write");
  // fixed and live bytes on the read path
  AST_CAL_READ: assert property (@(posedge clk) disable iff (reset)
    (s_arvalid && s_arready && s_araddr[9:2] >= OFF_CAL_FIRST
     && s_araddr[9:2] <= OFF_CAL_LAST) |=> s_rdata[7:0] == CAL_DEFAULT)
    else $error("calibration byte not default");
  AST_CKSUM_READ: assert property (@(posedge clk) disable iff (reset)
    seq_rd_at(OFF_CHECKSUM) |=> s_rdata[7:0] == CHECKSUM_DEFAULT)
    else $error("checksum byte wrong");
  AST_CTRL_READ: assert property (@(posedge clk) disable iff (reset)
    seq_rd_at(OFF_CTRL_STATE) |=> s_rdata[7:0] == {$past(state_reg.hw_off),
      $past(state_reg.sw_off), 3'b000, $past(state_reg.fault), $past(state_reg.loss),
      !$past(state_reg.ready)})
    else $error("control byte read wrong");
  AST_LIVE_TXP: assert property (@(posedge clk) disable iff (reset)
    seq_rd_at(OFF_LIVE_TXP_HI) |=> s_rdata[7:0] == $past(state_reg.meas.txp[15:8]))
    else $error("live transmit power high byte wrong");
  AST_LIVE_TEMP: assert property (@(posedge clk) disable iff (reset)
    seq_rd_at(OFF_LIVE_BASE) |=> s_rdata[7:0] == $past(state_reg.meas.temp[15:8]))
    else $error("live temperature high byte wrong");
  AST_WARN_B_RES: assert property (@(posedge clk) disable iff (reset)
    seq_rd_at(OFF_WARN_B) |=> s_rdata[5:0] == 6'h00)
    else $error("reserved warning bits set");
  // data-ready stays once reached
  AST_READY_HOLD: assert property (@(posedge clk) disable iff (reset)
    state_reg.ready |=> state_reg.ready)
    else $error("ready fell");
  // flag compares
  AST_FLAGS_HOLD: assert property (@(posedge clk) disable iff (reset)
    !meas_strobe
    |=> $stable(state_reg.alarm_a) && $stable(state_reg.warn_a))
    else $error("flags moved without measurement");
  AST_RX_HI: assert property (@(posedge clk) disable iff (reset)
    meas_strobe |=> state_reg.alarm_b[1] ==
      (state_reg.meas.rxp > $past(thr16(state_reg.thr, 32))))
    else $error("rx power high alarm wrong");
  AST_VCC_HI_WARN: assert property (@(posedge clk) disable iff (reset)
    meas_strobe |=> state_reg.warn_a[5] ==
      (state_reg.meas.vcc > $past(thr16(state_reg.thr, 12))))
    else $error("supply high warning wrong");
  AST_TEMP_HI_WARN: assert property (@(posedge clk) disable iff (reset)
    meas_strobe |=> state_reg.warn_a[7] ==
      ($signed(state_reg.meas.temp) > $signed($past(thr16(state_reg.thr, 4)))))
    else $error("temp high warning wrong");
  AST_BIAS_LO: assert property (@(posedge clk) disable iff (reset)
    meas_strobe |=> state_reg.alarm_a[2] ==
      (state_reg.meas.bias < $past(thr16(state_reg.thr, 18))))
    else $error("bias low alarm wrong");
  AST_RX_LO_WARN: assert property (@(posedge clk) disable iff (reset)
    meas_strobe |=> state_reg.warn_b[0] ==
      (state_reg.meas.rxp < $past(thr16(state_reg.thr, 38))))
    else $error("rx power low warning wrong");
endmodule // odm_diag_map

// ===== verilog/odm_pkg.sv
package odm_pkg;
  // byte offsets of the diagnostic space (bus byte address == 4 * byte index)
  localparam logic [7:0] OFF_THR_BASE = 8'h00; // 40 threshold bytes 0..39
  localparam logic [7:0] OFF_BIAS_LW_LO = 8'h17;
  localparam logic [7:0] OFF_TXP_HA_HI = 8'h18;
  localparam logic [7:0] OFF_TXP_HA_LO = 8'h19;
  localparam logic [7:0] OFF_CAL_FIRST = 8'h38;
  localparam logic [7:0] OFF_CAL_LAST = 8'h5e;
  localparam logic [7:0] OFF_CHECKSUM = 8'h5f;
  localparam logic [7:0] OFF_LIVE_BASE = 8'h60; // 96..105 live values
  localparam logic [7:0] OFF_LIVE_TXP_HI = 8'h66;
  localparam logic [7:0] OFF_LIVE_TXP_LO = 8'h67;
  localparam logic [7:0] OFF_CTRL_STATE = 8'h6e;
  localparam logic [7:0] OFF_ALARM_A = 8'h70;
  localparam logic [7:0] OFF_ALARM_B = 8'h71;
  localparam logic [7:0] OFF_WARN_A = 8'h74;
  localparam logic [7:0] OFF_WARN_B = 8'h75;
  localparam logic [7:0] OFF_SENSOR_LOAD = 8'h80;
  localparam int THR_BYTES = 40;
  // control byte fields
  localparam int CS_HW_OFF_BIT = 7;
  localparam int CS_SW_OFF_BIT = 6;
  localparam int CS_FAULT_BIT = 2;
  localparam int CS_LOSS_BIT = 1;
  localparam int CS_NOT_READY_BIT = 0;
  localparam logic [7:0] CAL_DEFAULT = 8'h00; // default constant bytes
  localparam logic [7:0] CHECKSUM_DEFAULT = 8'h00; // arbitrary, set at ship
  // soft command response time
  localparam int CLK_MHZ = 125;
  localparam int SOFT_RESP_MS = 100;
  localparam int SOFT_RESP_CYC = SOFT_RESP_MS * 1000 * CLK_MHZ;
  // units: temp 1/256 C signed, vcc 100 uV, bias 2 uA, power 0.1 uW
  typedef struct packed {
    logic signed [15:0] temp;
    logic [15:0] vcc;
    logic [15:0] bias;
    logic [15:0] txp;
    logic [15:0] rxp;
  } odm_meas_s;
  typedef struct packed {
    logic awready;
    logic wready;
    logic bvalid;
    logic arready;
    logic rvalid;
    logic [31:0] rdata;
    logic [1:0] rresp;
    logic [1:0] bresp;
  } odm_axi_out_s;
endpackage

// ===== tb/odm_host_model.sv
`timescale 1ns/1ps
// host controller as register bus master
module odm_host_model import odm_pkg::*; (
  // clock
  input wire logic clk,
  // write channels
  output logic [31:0] s_awaddr,
  output logic s_awvalid,
  input wire logic s_awready,
  output logic [31:0] s_wdata,
  output logic [3:0] s_wstrb,
  output logic s_wvalid,
  input wire logic s_wready,
  input wire logic [1:0] s_bresp,
  input wire logic s_bvalid,
  output logic s_bready,
  // read channels
  output logic [31:0] s_araddr,
  output logic s_arvalid,
  input wire logic s_arready,
  input wire logic [31:0] s_rdata,
  input wire logic [1:0] s_rresp,
  input wire logic s_rvalid,
  output logic s_rready
);
  // idle bus from time zero
  initial begin
    {s_awaddr, s_awvalid, s_wdata, s_wstrb, s_wvalid, s_bready} = '0;
    {s_araddr, s_arvalid, s_rready} = '0;
  end
  // one write of byte idx, word address is four times the index
  task automatic wr(input logic [7:0] idx, input logic [7:0] d, output logic [1:0] resp);
    @(posedge clk);
    s_awaddr <= {22'h0, idx, 2'h0};
    s_wdata <= {24'h0, d};
    s_wstrb <= 4'hf;
    s_awvalid <= 1'h1;
    s_wvalid <= 1'h1;
    s_bready <= 1'h1;
    forever begin
      @(posedge clk);
      if (s_awready) s_awvalid <= 1'h0;
      if (s_wready) s_wvalid <= 1'h0;
      if (s_bvalid) break;
    end
    resp = s_bresp;
    s_bready <= 1'h0;
  endtask
  // one read of byte idx
  task automatic rd(input logic [7:0] idx, output logic [31:0] d, output logic [1:0] resp);
    @(posedge clk);
    s_araddr <= {22'h0, idx, 2'h0};
    s_arvalid <= 1'h1;
    s_rready <= 1'h1;
    forever begin
      @(posedge clk);
      if (s_arready) s_arvalid <= 1'h0;
      if (s_rvalid) break;
    end
    d = s_rdata;
    resp = s_rresp;
    s_rready <= 1'h0;
  endtask
endmodule // odm_host_model

// ===== tb/odm_diag_map_tb.sv
`timescale 1ns/1ps
// self-checking bench for the diagnostic map
module odm_diag_map_tb import odm_pkg::*;;
  logic clk = 1'h0;
  logic reset = 1'h1;
  logic [31:0] s_awaddr, s_wdata, s_araddr, s_rdata;
  logic [3:0] s_wstrb;
  logic [1:0] s_bresp, s_rresp;
  logic s_awvalid, s_awready, s_wvalid, s_wready, s_bvalid, s_bready;
  logic s_arvalid, s_arready, s_rvalid, s_rready, tx_disable;
  odm_meas_s meas_in = '0;
  logic meas_strobe = 1'h0;
  logic tx_off_pin = 1'h0;
  logic tx_fault_pin = 1'h0;
  logic receive_signal_loss_output_pin = 1'h0;
  int n_fail = 0;
  int compares = 0;
  int cycles = 0;
  logic [7:0] thr [40] = '{default: 8'h0};
  logic [15:0] mv [5];
  // index in high byte, value in low byte
  logic [15:0] tw [7] = '{16'h0019, 16'h02fb, 16'h1740, 16'h1810, 16'h1955, 16'h2201, 16'h2408};
  odm_diag_map odm_diag_map_i (.*);
  odm_host_model odm_host_model_i (.*);
  // clock and hang guard
  always #4 clk = ~clk;
  always @(posedge clk) begin
    cycles++;
    if (cycles == 5000) begin
      n_fail++;
      complete_run();
    end
  end
  task automatic complete_run();
    if (n_fail == 0 && compares > 0) $display("verification passed");
    else $display("verification failed");
    $finish;
  endtask
  task automatic chk_val(input logic [31:0] got, input logic [31:0] exp);
    compares++;
    if (got !== exp) begin
      n_fail++;
      $display("[FAIL] t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask
  task automatic chk_resp(input logic [1:0] got, input logic [1:0] exp);
    compares++;
    if (got !== exp) begin
      n_fail++;
      $display("[FAIL] t=%0t resp got=%h exp=%h", $time, got, exp);
    end
  endtask
  // read a byte, expect it in the low bits and an okay answer
  task automatic rdc(input logic [7:0] idx, input logic [7:0] e);
    logic [31:0] d;
    logic [1:0] r;
    odm_host_model_i.rd(idx, d, r);
    chk_val(d, {24'h0, e});
    chk_resp(r, 2'h0);
  endtask
  task automatic wrc(input logic [7:0] idx, input logic [7:0] v);
    logic [1:0] r;
    odm_host_model_i.wr(idx, v, r);
    chk_resp(r, 2'h0);
    if (idx < 8'(THR_BYTES)) thr[idx] = v;
  endtask
  // flags from shadow thresholds; sign bit flipped makes temperature compare signed
  function automatic logic [15:0] exp_flags(input int w);
    logic [15:0] f, hi, lo, sv;
    f = '0;
    for (int q = 0; q < 5; q++) begin
      sv = (q == 0) ? 16'h8000 : 16'h0;
      hi = {thr[8*q+4*w], thr[8*q+4*w+1]} ^ sv;
      lo = {thr[8*q+4*w+2], thr[8*q+4*w+3]} ^ sv;
      f[15-2*q] = (mv[q] ^ sv) > hi;
      f[14-2*q] = (mv[q] ^ sv) < lo;
    end
    return f;
  endfunction
  // one measurement strobe, then all live bytes and flag bytes
  task automatic t_meas(input logic [15:0] t, v, b, tp, rp);
    logic [15:0] a, w;
    mv = '{t, v, b, tp, rp};
    @(posedge clk);
    meas_in <= {t, v, b, tp, rp};
    meas_strobe <= 1'h1;
    @(posedge clk);
    meas_strobe <= 1'h0;
    repeat (2) @(posedge clk);
    for (int i = 0; i < 10; i++) rdc(8'(OFF_LIVE_BASE + i), i[0] ? mv[i/2][7:0] : mv[i/2][15:8]);
    a = exp_flags(0);
    w = exp_flags(1);
    rdc(OFF_ALARM_A, a[15:8]);
    rdc(OFF_ALARM_B, a[7:0]);
    rdc(OFF_WARN_A, w[15:8]);
    rdc(OFF_WARN_B, w[7:0]);
  endtask
  task automatic set_pins(input logic [2:0] p);
    @(posedge clk);
    {tx_off_pin, tx_fault_pin, receive_signal_loss_output_pin} <= p;
    repeat (6) @(posedge clk);
  endtask
  task automatic t_txoff();
    wrc(OFF_CTRL_STATE, 8'hff);
    repeat (3) @(posedge clk);
    chk_val(32'(tx_disable), 32'h1);
    rdc(OFF_CTRL_STATE, 8'h40);
    set_pins(3'h7);
    rdc(OFF_CTRL_STATE, 8'hc6);
    wrc(OFF_CTRL_STATE, 8'h00);
    repeat (3) @(posedge clk);
    chk_val(32'(tx_disable), 32'h1);
    set_pins(3'h1);
    rdc(OFF_CTRL_STATE, 8'h02);
    chk_val(32'(tx_disable), 32'h0);
  endtask
  task automatic t_misc();
    logic [31:0] d;
    logic [1:0] r;
    rdc(OFF_CHECKSUM, CHECKSUM_DEFAULT);
    rdc(OFF_CAL_FIRST, CAL_DEFAULT);
    rdc(OFF_CAL_LAST, CAL_DEFAULT);
    wrc(8'h28, 8'h5a);
    rdc(8'h28, 8'h00);
    odm_host_model_i.rd(8'hc8, d, r);
    chk_resp(r, 2'h2);
    odm_host_model_i.wr(8'hc8, 8'h11, r);
    chk_resp(r, 2'h2);
  endtask
  // main sequence
  initial begin
    repeat (2) @(posedge clk);
    reset <= 1'h0;
    rdc(OFF_CTRL_STATE, 8'h01);
    chk_val(32'(tx_disable), 32'h0);
    for (int i = 0; i < 7; i++) wrc(tw[i][15:8], tw[i][7:0]);
    rdc(OFF_BIAS_LW_LO, 8'h40);
    rdc(OFF_TXP_HA_HI, 8'h10);
    rdc(OFF_TXP_HA_LO, 8'h55);
    wrc(OFF_LIVE_TXP_HI, 8'haa);
    t_meas(16'hf600, 16'h8000, 16'h0020, 16'h1234, 16'h0080);
    rdc(OFF_CTRL_STATE, 8'h00);
    t_meas(16'h1a00, 16'h0000, 16'h0100, 16'h0fff, 16'h0900);
    t_txoff();
    t_misc();
    complete_run();
  end
endmodule // odm_diag_map_tb
